// ==== logic/port_ctrl.sv ====
// Purpose: Port B and port G pad control with alternate functions.
// Assumes: Pin inputs are synchronous to clk_sys; APB slave, no waits.
// Notes: A read is captured in the setup cycle and shown in the access.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module port_ctrl (
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [port_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Port B pads.
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  output logic [7:0] pb_pullup,
  // Port G pads.
  input wire logic [5:0] pg_in,
  output logic [5:0] pg_out,
  output logic [5:0] pg_oe,
  output logic [5:0] pg_pullup,
  output logic [5:0] pg_input_enable,
  // Alternate-function sources.
  input wire logic timer0_compare_b_out,
  input wire logic timer0_compare_b_enable,
  input wire logic antenna_diversity_out,
  input wire logic rxtx_indicator_out,
  // Alternate-function sinks.
  output logic osc_amp_input_pin,
  output logic osc_amp_output_pin,
  output logic meter_count_input,
  output logic meter_clock_active,
  // Driver strength codes per port and per port G pin.
  output logic [1:0] strength_field_f,
  output logic [1:0] strength_field_e,
  output logic [1:0] strength_field_d,
  output logic [1:0] strength_field_b,
  output logic [1:0] strength_field_g,
  output logic [11:0] pg_pin_strength
);

  logic [7:0] pb_dir_q;
  logic [7:0] pb_data_q;
  logic [7:0] strength0_q;
  logic [1:0] strength1_q;
  logic [7:0] mcu_ctrl_q;
  logic [4:0] alt_ctrl_q;
  logic [5:0] pg_dir_q;
  logic [5:0] pg_data_q;
  logic [31:0] prdata_q;
  logic err_q;
  logic [9:0] idx;
  logic aligned;
  logic setup;
  logic wr;
  logic hit;
  logic [7:0] rd_byte;
  logic [7:0] wbyte;
  logic pullup_global_disable;
  logic async_clock_select;
  logic meter_input_clock_select;
  logic external_clock_select;
  logic antenna_switch_out_enable;
  logic frontend_indicator_enable;
  logic crystal_pg4;
  logic crystal_pg3;
  logic meter_mode;
  logic [5:0] pullup_override_enable;
  logic [5:0] pullup_override_value;
  logic [5:0] direction_override_enable;
  logic [5:0] direction_override_value;
  logic [5:0] output_value_override_enable;
  logic [5:0] output_value_override_value;
  logic [5:0] input_enable_override_enable;
  logic [5:0] input_enable_override_value;
  logic [5:0] pg_pin_level;

  // Bus decode: index from the word address.
  assign idx = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);
  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && !err_q;
  assign wbyte = pwdata[7:0];

  // The slave never inserts wait states.
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;
  assign prdata = prdata_q;

  // Named control bits.
  assign pullup_global_disable = mcu_ctrl_q[port_ctrl_pkg::PUD_BIT];
  assign async_clock_select = alt_ctrl_q[port_ctrl_pkg::ALT_ASYNC_BIT];
  assign meter_input_clock_select = alt_ctrl_q[port_ctrl_pkg::ALT_METER_BIT];
  assign external_clock_select = alt_ctrl_q[port_ctrl_pkg::ALT_EXTCLK_BIT];
  assign antenna_switch_out_enable = alt_ctrl_q[port_ctrl_pkg::ALT_ANT_BIT];
  assign frontend_indicator_enable = alt_ctrl_q[port_ctrl_pkg::ALT_FE_BIT];

  // Oscillator and meter mode conditions.
  assign crystal_pg4 = async_clock_select && !meter_input_clock_select;
  assign crystal_pg3 = crystal_pg4 && !external_clock_select;
  assign meter_mode = async_clock_select && meter_input_clock_select;

  // Read mux: selects the addressed register for the setup cycle.
  always_comb begin
    hit = aligned;
    rd_byte = port_ctrl_pkg::RST_BYTE;
    unique case (idx)
      port_ctrl_pkg::IDX_PB_DIR: rd_byte = pb_dir_q;
      port_ctrl_pkg::IDX_STRENGTH0: rd_byte = strength0_q;
      port_ctrl_pkg::IDX_STRENGTH1: rd_byte = {6'h00, strength1_q};
      port_ctrl_pkg::IDX_PB_DATA: rd_byte = pb_data_q;
      port_ctrl_pkg::IDX_PB_PIN: rd_byte = pb_in;
      port_ctrl_pkg::IDX_MCU_CTRL: rd_byte = mcu_ctrl_q;
      port_ctrl_pkg::IDX_ALT_CTRL: rd_byte = {3'h0, alt_ctrl_q};
      port_ctrl_pkg::IDX_PG_DIR: rd_byte = {2'h0, pg_dir_q};
      port_ctrl_pkg::IDX_PG_DATA: rd_byte = {2'h0, pg_data_q};
      port_ctrl_pkg::IDX_PG_PIN: rd_byte = {2'h0, pg_pin_level};
      default: hit = 1'b0;
    endcase
  end

  // Read data and error flag are captured in the setup cycle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (setup) begin
      prdata_q <= {24'h00_0000, rd_byte};
      err_q <= !hit;
    end
  end

  // Port B direction register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pb_dir_q <= port_ctrl_pkg::RST_BYTE;
    end else if (wr && idx == port_ctrl_pkg::IDX_PB_DIR) begin
      pb_dir_q <= wbyte;
    end
  end

  // Port B data register, written directly or toggled through the pin register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pb_data_q <= port_ctrl_pkg::RST_BYTE;
    end else if (wr && idx == port_ctrl_pkg::IDX_PB_DATA) begin
      pb_data_q <= wbyte;
    end else if (wr && idx == port_ctrl_pkg::IDX_PB_PIN) begin
      pb_data_q <= pb_data_q ^ wbyte;
    end
  end

  // Driver strength registers.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      strength0_q <= port_ctrl_pkg::RST_BYTE;
      strength1_q <= 2'h0;
    end else if (wr && idx == port_ctrl_pkg::IDX_STRENGTH0) begin
      strength0_q <= wbyte;
    end else if (wr && idx == port_ctrl_pkg::IDX_STRENGTH1) begin
      strength1_q <= wbyte[1:0] & port_ctrl_pkg::STRENGTH1_MASK[1:0];
    end
  end

  // General control register holding the pull-up disable.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mcu_ctrl_q <= port_ctrl_pkg::RST_BYTE;
    end else if (wr && idx == port_ctrl_pkg::IDX_MCU_CTRL) begin
      mcu_ctrl_q <= wbyte;
    end
  end

  // Alternate-function select register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alt_ctrl_q <= 5'h00;
    end else if (wr && idx == port_ctrl_pkg::IDX_ALT_CTRL) begin
      alt_ctrl_q <= wbyte[4:0] & port_ctrl_pkg::ALT_MASK;
    end
  end

  // Port G direction and data, with toggle through the pin register.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pg_dir_q <= port_ctrl_pkg::RST_PG;
      pg_data_q <= port_ctrl_pkg::RST_PG;
    end else if (wr && idx == port_ctrl_pkg::IDX_PG_DIR) begin
      pg_dir_q <= wbyte[5:0];
    end else if (wr && idx == port_ctrl_pkg::IDX_PG_DATA) begin
      pg_data_q <= wbyte[5:0];
    end else if (wr && idx == port_ctrl_pkg::IDX_PG_PIN) begin
      pg_data_q <= pg_data_q ^ wbyte[5:0];
    end
  end

  // Port B pads: no alternate functions in this block.
  always_comb begin
    pb_oe = pb_dir_q;
    pb_out = pb_data_q;
    pb_pullup = ~pb_dir_q & pb_data_q & {8{!pullup_global_disable}};
  end

  // Port G override table, one column per pin.
  always_comb begin
    pullup_override_enable = 6'h00;
    pullup_override_value = 6'h00;
    direction_override_enable = 6'h00;
    direction_override_value = 6'h00;
    output_value_override_enable = 6'h00;
    output_value_override_value = 6'h00;
    input_enable_override_enable = 6'h00;
    input_enable_override_value = 6'h00;
    // Compare output sets the PG5 output value when the timer enables it; direction stays with pg_dir_q.
    output_value_override_enable[port_ctrl_pkg::PG_CMP] =
      timer0_compare_b_enable;
    output_value_override_value[port_ctrl_pkg::PG_CMP] =
      timer0_compare_b_out;
    // Crystal input pin.
    pullup_override_enable[port_ctrl_pkg::PG_OSC_IN] = crystal_pg4;
    direction_override_enable[port_ctrl_pkg::PG_OSC_IN] = crystal_pg4;
    input_enable_override_enable[port_ctrl_pkg::PG_OSC_IN] = crystal_pg4;
    input_enable_override_value[port_ctrl_pkg::PG_OSC_IN] =
      external_clock_select;
    // Crystal output pin.
    pullup_override_enable[port_ctrl_pkg::PG_OSC_OUT] = crystal_pg3;
    direction_override_enable[port_ctrl_pkg::PG_OSC_OUT] = crystal_pg3;
    input_enable_override_enable[port_ctrl_pkg::PG_OSC_OUT] = crystal_pg3;
    // Meter counter input pin.
    pullup_override_enable[port_ctrl_pkg::PG_METER] = meter_mode;
    direction_override_enable[port_ctrl_pkg::PG_METER] = meter_mode;
    input_enable_override_enable[port_ctrl_pkg::PG_METER] = meter_mode;
    input_enable_override_value[port_ctrl_pkg::PG_METER] = 1'b1;
    // Antenna diversity output.
    direction_override_enable[port_ctrl_pkg::PG_ANT] =
      antenna_switch_out_enable;
    direction_override_value[port_ctrl_pkg::PG_ANT] =
      antenna_switch_out_enable;
    output_value_override_enable[port_ctrl_pkg::PG_ANT] =
      antenna_switch_out_enable;
    output_value_override_value[port_ctrl_pkg::PG_ANT] =
      antenna_diversity_out;
    // Front-end indicator output.
    direction_override_enable[port_ctrl_pkg::PG_IND] =
      frontend_indicator_enable;
    direction_override_value[port_ctrl_pkg::PG_IND] =
      frontend_indicator_enable;
    output_value_override_enable[port_ctrl_pkg::PG_IND] =
      frontend_indicator_enable;
    output_value_override_value[port_ctrl_pkg::PG_IND] =
      rxtx_indicator_out;
  end

  // Per-pin pad logic: an asserted override replaces the register path.
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_pg_pad
      always_comb begin
        pg_pullup[g] = pullup_override_enable[g] ?
          pullup_override_value[g] :
          (!pg_dir_q[g] && pg_data_q[g] && !pullup_global_disable);
        pg_oe[g] = direction_override_enable[g] ?
          direction_override_value[g] : pg_dir_q[g];
        pg_out[g] = output_value_override_enable[g] ?
          output_value_override_value[g] : pg_data_q[g];
        pg_input_enable[g] = input_enable_override_enable[g] ?
          input_enable_override_value[g] : 1'b1;
        pg_pin_level[g] = pg_in[g] && pg_input_enable[g];
      end
    end
  endgenerate

  // Oscillator pin routing and meter counter input.
  assign osc_amp_input_pin = crystal_pg4;
  assign osc_amp_output_pin = crystal_pg3;
  assign meter_count_input = pg_pin_level[port_ctrl_pkg::PG_METER];
  assign meter_clock_active = meter_mode;

  // Strength fields; PG3 and PG4 take no strength setting.
  assign strength_field_f = strength0_q[7:6];
  assign strength_field_e = strength0_q[5:4];
  assign strength_field_d = strength0_q[3:2];
  assign strength_field_b = strength0_q[1:0];
  assign strength_field_g = strength1_q;
  assign pg_pin_strength = {strength1_q, 2'h0, 2'h0, strength1_q,
                            strength1_q, strength1_q};

endmodule : port_ctrl

// ==== logic/port_ctrl_pkg.sv ====
// Purpose: Constants shared by the port alternate-function and pin block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes: Register byte address is four times the register index.
//
// Overview of operation
// - Crystal mode: PG4 becomes oscillator input.
// - Crystal mode: PG3 becomes oscillator output.
// - Meter mode: PG2 forced input, feeds counter.
// - Antenna switch enable drives diversity on PG1.
// - Front-end enable drives RX/TX indicator on PG0.
// - PG4, PG3 gating; PG5 follows compare output.
// - PG1, PG0 direction and value overrides only.
// - Global pull-up disable turns every pull-up off.
// - Strength register 0: four 2-bit fields, reset zero.
// - Strength register 1: G field, upper bits zero.
// - Port B input pull-up follows data bit.
// - Port B output drives its data bit.
// - Direction bit one means output; reset zero.
// - Port B input register reads actual pins.
// - Writing one to input register toggles data.
package port_ctrl_pkg;

  localparam int ADDR_W = 12;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_PB_DIR = 10'h004;
  localparam logic [9:0] IDX_STRENGTH0 = 10'h136;
  localparam logic [9:0] IDX_STRENGTH1 = 10'h137;
  localparam logic [9:0] IDX_PB_DATA = 10'h140;
  localparam logic [9:0] IDX_PB_PIN = 10'h141;
  localparam logic [9:0] IDX_MCU_CTRL = 10'h142;
  localparam logic [9:0] IDX_ALT_CTRL = 10'h143;
  localparam logic [9:0] IDX_PG_DIR = 10'h144;
  localparam logic [9:0] IDX_PG_DATA = 10'h145;
  localparam logic [9:0] IDX_PG_PIN = 10'h146;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_PG = 6'h00;

  // Field positions.
  localparam int PUD_BIT = 4;
  localparam int ALT_ASYNC_BIT = 0;
  localparam int ALT_METER_BIT = 1;
  localparam int ALT_EXTCLK_BIT = 2;
  localparam int ALT_ANT_BIT = 3;
  localparam int ALT_FE_BIT = 4;
  localparam logic [4:0] ALT_MASK = 5'h1f;
  localparam logic [7:0] STRENGTH1_MASK = 8'h03;

  // Port G pin numbers with special functions.
  localparam int PG_IND = 0;
  localparam int PG_ANT = 1;
  localparam int PG_METER = 2;
  localparam int PG_OSC_OUT = 3;
  localparam int PG_OSC_IN = 4;
  localparam int PG_CMP = 5;

endpackage : port_ctrl_pkg

// ==== tb/port_ctrl_pads.sv ====
// Purpose: Board side of the port pads.
// Assumes: Chip drive wins, then a board driver, then the pull-up.
// Notes: A pad nobody drives reads low through a weak board pull-down.
`timescale 1ns/1ps
module port_ctrl_pads #(
  parameter int W = 8
) (
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] pull,
  input wire logic [W-1:0] ext_en,
  input wire logic [W-1:0] ext_val,
  output logic [W-1:0] pin
);
  // Resolve each pad from whichever party drives it.
  assign pin = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pull);
endmodule : port_ctrl_pads

// ==== tb/port_ctrl_properties.sv ====
// Purpose: Port-level assertions for the port control block.
// Assumes: Only top-level ports are visible.
// Notes: Bound into every port_ctrl instance below.
`timescale 1ns/1ps
module port_ctrl_props (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [port_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  input wire logic [7:0] pb_pullup,
  input wire logic [5:0] pg_in,
  input wire logic [5:0] pg_out,
  input wire logic [5:0] pg_oe,
  input wire logic [5:0] pg_pullup,
  input wire logic [5:0] pg_input_enable,
  input wire logic timer0_compare_b_out,
  input wire logic timer0_compare_b_enable,
  input wire logic antenna_diversity_out,
  input wire logic osc_amp_input_pin,
  input wire logic osc_amp_output_pin,
  input wire logic meter_count_input,
  input wire logic meter_clock_active,
  input wire logic [1:0] strength_field_g,
  input wire logic [11:0] pg_pin_strength
);
  // Completed writes and the data they carry.
  wire logic wr = psel & penable & pwrite & (paddr[1:0] == 2'h0);
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic [9:0] idx = paddr[11:2];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  property p_pull_out; (pb_pullup & pb_oe) == 8'h00; endproperty
  a_pull_out: assert property (p_pull_out)
    else $error("pull-up on an output pin");
  property p_pull_data; (pb_pullup & ~pb_out) == 8'h00; endproperty
  a_pull_data: assert property (p_pull_data)
    else $error("pull-up with data bit low");
  property p_toggle;
    wr && idx == port_ctrl_pkg::IDX_PB_PIN
    |=> pb_out == ($past(pb_out) ^ $past(wbyte));
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("pin write did not toggle data");
  property p_ant;
    wr && idx == port_ctrl_pkg::IDX_ALT_CTRL
    && wbyte[port_ctrl_pkg::ALT_ANT_BIT] |=> pg_oe[1]
    && pg_out[1] == antenna_diversity_out && pg_input_enable[1];
  endproperty
  a_ant: assert property (p_ant)
    else $error("antenna output not on its pin");
  property p_meter;
    meter_clock_active |-> !pg_oe[2] && !pg_pullup[2]
    && pg_input_enable[2] && meter_count_input == pg_in[2];
  endproperty
  a_meter: assert property (p_meter)
    else $error("meter pin not forced to input");
  property p_osc_in;
    osc_amp_input_pin |-> !pg_oe[4] && !pg_pullup[4] && !meter_clock_active;
  endproperty
  a_osc_in: assert property (p_osc_in)
    else $error("oscillator input pin still driven");
  property p_osc_out;
    osc_amp_output_pin |-> osc_amp_input_pin && !pg_oe[3] && !pg_pullup[3];
  endproperty
  a_osc_out: assert property (p_osc_out)
    else $error("oscillator output pin still driven");
  property p_cmp;
    timer0_compare_b_enable |-> pg_out[5] == timer0_compare_b_out;
  endproperty
  a_cmp: assert property (p_cmp)
    else $error("compare output not on its pin");
  property p_pin_str;
    pg_pin_strength == {strength_field_g, 4'h0, {3{strength_field_g}}};
  endproperty
  a_pin_str: assert property (p_pin_str)
    else $error("pin strength map wrong");
  c_meter: cover property (meter_clock_active && meter_count_input == 1'b0);
  c_osc: cover property (osc_amp_input_pin && !osc_amp_output_pin);
  c_toggle: cover property (wr && idx == port_ctrl_pkg::IDX_PB_PIN);
endmodule : port_ctrl_props
bind port_ctrl port_ctrl_props port_ctrl_props_i (.clk_sys, .rst, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pb_out, .pb_oe, .pb_pullup, .pg_in,
  .pg_out, .pg_oe, .pg_pullup, .pg_input_enable, .timer0_compare_b_out,
  .timer0_compare_b_enable, .antenna_diversity_out, .osc_amp_input_pin,
  .osc_amp_output_pin, .meter_count_input, .meter_clock_active,
  .strength_field_g, .pg_pin_strength);

// ==== tb/port_ctrl_test.sv ====
// Purpose: Self-checking bench for the port control block.
// Assumes: The APB slave answers through pready; pads sit on a board model.
// Notes: Register cases are table rows; pads, modes and reset follow.
`timescale 1ns/1ps
module port_ctrl_test;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic pready, pslverr, osc_i, osc_o, mtr_in, mtr_on;
  logic cmp_o = 0, cmp_en = 1, ant = 0, rxtx = 0;
  logic [port_ctrl_pkg::ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pu, xb_en = '0, xb_val = '0;
  logic [5:0] pg_in, pg_out, pg_oe, pg_pu, pg_ie, xg_en = '0, xg_val = '0;
  logic [1:0] sf, se, sd, sb, sg;
  logic [11:0] pg_str;
  int n_errors = 0;
  int checks_done = 0;
  typedef struct {logic [9:0] idx; logic [7:0] wd, exp;} row_t;
  row_t rows[6];
  logic [7:0] am[5] = '{8'h00, 8'h01, 8'h05, 8'h03, 8'h18};
  logic [9:0] ae[5] = '{10'h23f, 10'h1a7, 10'h32f, 10'h27b, 10'h23f};
  port_ctrl port_ctrl_i (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .pb_in, .pb_out, .pb_oe,
    .pb_pullup(pb_pu), .pg_in, .pg_out, .pg_oe, .pg_pullup(pg_pu),
    .pg_input_enable(pg_ie), .timer0_compare_b_out(cmp_o),
    .timer0_compare_b_enable(cmp_en), .antenna_diversity_out(ant),
    .rxtx_indicator_out(rxtx), .osc_amp_input_pin(osc_i),
    .osc_amp_output_pin(osc_o), .meter_count_input(mtr_in),
    .meter_clock_active(mtr_on), .strength_field_f(sf), .strength_field_e(se),
    .strength_field_d(sd), .strength_field_b(sb), .strength_field_g(sg),
    .pg_pin_strength(pg_str));
  port_ctrl_pads #(.W(8)) pads_b_i (.oe(pb_oe), .out(pb_out), .pull(pb_pu),
    .ext_en(xb_en), .ext_val(xb_val), .pin(pb_in));
  port_ctrl_pads #(.W(6)) pads_g_i (.oe(pg_oe), .out(pg_out), .pull(pg_pu),
    .ext_en(xg_en), .ext_val(xg_val), .pin(pg_in));
  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Count and report one comparison.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; read data and error are taken at the ready edge.
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // Wait as long as the slave needs; only the watchdog ends a hang.
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Let pads and the combinational pin samples settle.
  task automatic settle();
    repeat (3) @(negedge clk_sys);
  endtask : settle
  // Print the counts and the verdict, then stop.
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  // Cut a hung run short.
  initial begin
    #50000;
    n_errors++;
    tally_and_finish();
  end
  // Main sequence: register rows, pads, modes, then a second reset.
  initial begin
    rows = '{'{port_ctrl_pkg::IDX_PB_DIR, 8'h0f, 8'h0f},
      '{port_ctrl_pkg::IDX_STRENGTH0, 8'he4, 8'he4},
      '{port_ctrl_pkg::IDX_STRENGTH1, 8'hff, 8'h03},
      '{port_ctrl_pkg::IDX_PB_DATA, 8'ha5, 8'ha5},
      '{port_ctrl_pkg::IDX_PG_DIR, 8'h3f, 8'h3f},
      '{port_ctrl_pkg::IDX_PG_DATA, 8'h3f, 8'h3f}};
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].wd);
      apb(1'b0, rows[i].idx, 8'h00);
      chk(rd, {24'h0, rows[i].exp});
    end
    settle();
    chk({sf, se, sd, sb, sg}, 32'h393);
    chk(pg_str, 32'hc3f);
    chk({pb_oe, pb_out, pb_pu}, 32'h0fa5a0);
    apb(1'b0, port_ctrl_pkg::IDX_PB_PIN, 8'h00);
    chk(rd, 32'ha5);
    xb_en <= 8'hf0;
    xb_val <= 8'h30;
    settle();
    apb(1'b0, port_ctrl_pkg::IDX_PB_PIN, 8'h00);
    chk(rd, 32'h35);
    apb(1'b1, port_ctrl_pkg::IDX_MCU_CTRL, 8'h10);
    xb_en <= 8'h00;
    settle();
    chk(pb_pu, 32'h00);
    apb(1'b0, port_ctrl_pkg::IDX_PB_PIN, 8'h00);
    chk(rd, 32'h05);
    apb(1'b1, port_ctrl_pkg::IDX_PB_PIN, 8'h0f);
    apb(1'b0, port_ctrl_pkg::IDX_PB_DATA, 8'h00);
    chk(rd, 32'haa);
    chk(pb_out, 32'haa);
    apb(1'b0, 10'h3ff, 8'h00);
    chk({err, |rd}, 32'h2);
    foreach (am[i]) begin
      apb(1'b1, port_ctrl_pkg::IDX_ALT_CTRL, am[i]);
      settle();
      chk({pg_ie[4], osc_i, osc_o, mtr_on, pg_oe}, ae[i]);
    end
    chk({pg_out, pg_pu}, 32'h700);
    apb(1'b1, port_ctrl_pkg::IDX_ALT_CTRL, 8'h03);
    xg_en <= 6'h04;
    xg_val <= 6'h04;
    settle();
    chk({mtr_in, pg_oe[2], pg_ie[2]}, 32'h5);
    apb(1'b0, port_ctrl_pkg::IDX_PG_PIN, 8'h00);
    chk(rd, 32'h1f);
    cmp_en <= 1'b0;
    settle();
    chk(pg_out, 32'h3f);
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    settle();
    chk({pb_oe, pb_out, sf, se, sd, sb, sg}, 32'h0);
    apb(1'b0, port_ctrl_pkg::IDX_PB_DIR, 8'h00);
    chk(rd, 32'h0);
    tally_and_finish();
  end
endmodule : port_ctrl_test
